/* File: hw/ccs_pkg.sv */
// constants shared by the processor clock control block
package ccs_pkg;
  // register port and field layout
  localparam logic [15:0] CCS_REG_ADDR = 16'h1072;
  localparam int CCS_SRC_BIT = 15;
  localparam int CCS_NOM_LSB = 12;
  localparam int CCS_AUTO_BIT = 11;
  localparam int CCS_ALT_LSB = 8;
  localparam int CCS_EXT_LSB = 4;
  localparam int CCS_STOP_ON_HALT_AND_HOLD_BIT = 1;
  localparam int CCS_SCH_BIT = 0;
  // reset values
  localparam logic CCS_SRC_RST = 1'b0;
  localparam logic [2:0] CCS_NOM_RST = 3'h1;
  localparam logic CCS_AUTO_RST = 1'b0;
  localparam logic [2:0] CCS_ALT_RST = 3'h0;
  localparam logic [3:0] CCS_EXT_RST = 4'h0;
  localparam logic CCS_STOP_RST = 1'b0;
  // divider codes
  localparam logic [2:0] CCS_DIV_INPUT = 3'h0;
  localparam logic [2:0] CCS_DIV_1 = 3'h1;
  localparam logic [2:0] CCS_DIV_2 = 3'h2;
  localparam logic [2:0] CCS_DIV_4_LO = 3'h3;
  localparam logic [2:0] CCS_DIV_4_HI = 3'h4;
  localparam logic [2:0] CCS_DIV_8_LO = 3'h5;
  localparam logic [2:0] CCS_DIV_8_HI = 3'h6;
  // multiplexer select codes
  localparam logic [2:0] CCS_MUX_FAST = 3'h0;
  localparam logic [2:0] CCS_MUX_STRAP = 3'h4;
  // timing
  localparam int CCS_CLK_MHZ = 250;
  localparam int CCS_LONG_WINDOW_S = 1;
  localparam int CCS_SHORT_WINDOW_MS = 1;
  localparam int CCS_HOLD_STEP_US = 1;
  localparam int CCS_LONG_CYCLES = CCS_LONG_WINDOW_S * CCS_CLK_MHZ * 1000000;
  localparam int CCS_SHORT_CYCLES = CCS_SHORT_WINDOW_MS * CCS_CLK_MHZ * 1000;
  localparam int CCS_HOLD_STEP_CYCLES = CCS_HOLD_STEP_US * CCS_CLK_MHZ;
  // sequencing after reset
  typedef enum logic [1:0] {
    CCS_ST_RESET = 2'b00,
    CCS_ST_STRAP = 2'b01,
    CCS_ST_RUN = 2'b10
  } ccs_seq_e;
endpackage

/* File: hw/ccs_clk_div.sv */
// processor clock divider with boundary-aligned setting changes
`timescale 1ns/100ps
`default_nettype none
module ccs_clk_div
  import ccs_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // source and control
  input wire logic srcClk,
  input wire logic [2:0] divCode,
  input wire logic stopReq,
  // generated clock
  output logic processorClock,
  output logic stopped
);
  logic srcPrev;
  logic srcRise;
  logic [2:0] phase;
  logic [2:0] activeCode;
  logic [2:0] lastPhase;

  assign srcRise = srcClk & ~srcPrev;

  always_comb begin
    case (activeCode)
      CCS_DIV_2: lastPhase = 3'h1;
      CCS_DIV_4_LO, CCS_DIV_4_HI: lastPhase = 3'h3;
      CCS_DIV_8_LO, CCS_DIV_8_HI: lastPhase = 3'h7;
      default: lastPhase = 3'h0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      srcPrev <= 1'b0;
    end else begin
      srcPrev <= srcClk;
    end
  end

  // new setting and stop taken only at the end of a divided period
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phase <= 3'h0;
      activeCode <= CCS_DIV_1;
      stopped <= 1'b0;
    end else if (srcRise) begin
      if (phase == lastPhase) begin
        phase <= 3'h0;
        activeCode <= divCode;
        stopped <= stopReq;
      end else begin
        phase <= phase + 3'h1;
      end
    end
  end

  // output waveform per divider code, low while stopped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      processorClock <= 1'b0;
    end else if (stopped) begin
      processorClock <= 1'b0;
    end else begin
      case (activeCode)
        CCS_DIV_1: processorClock <= srcClk;
        CCS_DIV_2: processorClock <= (phase == 3'h0);
        CCS_DIV_4_LO: processorClock <= (phase == 3'h0);
        CCS_DIV_4_HI: processorClock <= (phase != 3'h0);
        CCS_DIV_8_LO: processorClock <= (phase == 3'h0);
        CCS_DIV_8_HI: processorClock <= (phase != 3'h0);
        default: processorClock <= 1'b0;
      endcase
    end
  end
endmodule // ccs_clk_div
`default_nettype wire

/* File: hw/ccs_cpu_clock_ctrl.sv */
// processor clock speed control, hold extension and clock stop
//
// Overview of operation
// - auto off: fast-select level 0 picks nominal divider, level 1 alternate.
// - fast-select asserted always forces the nominal divider.
// - auto on, fast-select off: alternate, nominal during timed speedup windows.
// - disk, coprocessor, SCSI, floppy, port B: one second; keyboard ends on video.
// - video access or processor reset gives a one millisecond window.
// - other NMI or IRQ gives a one millisecond window.
// - alternate divider decode, 000 meaning keep nominal setting.
// - hold request extended after refresh by field value in microseconds.
// - hold extension acts as zero while fast-select is asserted.
// - halt-and-hold stop bit stops clock at next halt with hold.
// - interrupt restarts after halt-and-hold stop; the bit stays set.
// - hold stop bit stops clock at next processor hold cycle.
// - interrupt restarts after hold stop and clears the hold stop bit (cleared here only while the halt-and-hold bit is clear).
// - refresh keeps running while the processor clock is stopped.
// - multiplexer select lines show 100 during system reset.
// - strap at select 100 after reset sets nominal divider default and direction.
// - fast-select arrives on the power control input through the multiplexer.
// - nominal divider decode, 000 making the clock pin an input.
// - halt slows the clock unless a stop is programmed; interrupt restores.
`timescale 1ns/100ps
`default_nettype none
module ccs_cpu_clock_ctrl
  import ccs_pkg::*;
#(
  parameter int LONG_CYCLES = CCS_LONG_CYCLES,
  parameter int SHORT_CYCLES = CCS_SHORT_CYCLES
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioWrData,
  output logic [15:0] ioRdData,
  // multiplexed inputs
  output logic [2:0] muxSelect,
  input wire logic muxedRequestIn,
  input wire logic muxedPowerCtrlIn,
  // processor status
  input wire logic cpuHalt,
  input wire logic cpuHold,
  input wire logic intrEvt,
  input wire logic nmiEvt,
  // speedup activity pulses
  input wire logic slowIoEvt,
  input wire logic diskIrqEvt,
  input wire logic kbdIrqEvt,
  input wire logic otherIrqEvt,
  input wire logic videoEvt,
  input wire logic cpuResetEvt,
  // refresh
  input wire logic refreshDone,
  output logic holdExtend,
  // generated clock
  input wire logic srcClk,
  output logic processorClock,
  output logic processorClockOe,
  output logic clockSourceSel,
  output logic clockStopped
);
  ccs_seq_e seq;
  logic [2:0] nominalDivider;
  logic autoSpeedSwitchEn;
  logic [2:0] alternateDivider;
  logic [3:0] holdExtension;
  logic stopOnHaltAndHold;
  logic stopOnHold;
  logic fastLevel;
  logic fastAsserted;
  logic regHit;
  logic wakeEvt;
  logic stopReq;
  logic haltSlow;
  logic useAlt;
  logic [2:0] divCode;
  logic [31:0] windowCnt;
  logic kbdWindow;
  logic [11:0] holdCnt;
  logic [3:0] effExtension;
  logic divStopped;

  assign regHit = (ioAddr == CCS_REG_ADDR);
  assign wakeEvt = intrEvt | nmiEvt;
  assign fastAsserted = ~fastLevel;

  // reset sequencing, strap capture and select lines
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      seq <= CCS_ST_RESET;
      muxSelect <= CCS_MUX_STRAP;
    end else begin
      case (seq)
        CCS_ST_RESET: seq <= CCS_ST_STRAP;
        CCS_ST_STRAP: begin
          seq <= CCS_ST_RUN;
          muxSelect <= CCS_MUX_FAST;
        end
        CCS_ST_RUN: seq <= CCS_ST_RUN;
        default: seq <= CCS_ST_RESET;
      endcase
    end
  end

  // fast-select sampled only while the multiplexer points at it
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fastLevel <= 1'b1;
    end else if (seq == CCS_ST_RUN && muxSelect == CCS_MUX_FAST) begin
      fastLevel <= muxedPowerCtrlIn;
    end
  end

  // control register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clockSourceSel <= CCS_SRC_RST;
      nominalDivider <= CCS_NOM_RST;
      autoSpeedSwitchEn <= CCS_AUTO_RST;
      alternateDivider <= CCS_ALT_RST;
      holdExtension <= CCS_EXT_RST;
      stopOnHaltAndHold <= CCS_STOP_RST;
      stopOnHold <= CCS_STOP_RST;
    end else begin
      if (seq == CCS_ST_STRAP && muxedRequestIn) begin
        nominalDivider <= CCS_DIV_INPUT;
      end
      if (clockStopped && wakeEvt && !stopOnHaltAndHold) begin
        stopOnHold <= 1'b0;
      end
      if (ioWrite && regHit && seq == CCS_ST_RUN) begin
        clockSourceSel <= ioWrData[CCS_SRC_BIT];
        nominalDivider <= ioWrData[CCS_NOM_LSB +: 3];
        autoSpeedSwitchEn <= ioWrData[CCS_AUTO_BIT];
        alternateDivider <= ioWrData[CCS_ALT_LSB +: 3];
        holdExtension <= ioWrData[CCS_EXT_LSB +: 4];
        stopOnHaltAndHold <= ioWrData[CCS_STOP_ON_HALT_AND_HOLD_BIT];
        stopOnHold <= ioWrData[CCS_SCH_BIT];
      end
    end
  end

  // read data, reserved bits read as zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ioRdData <= 16'h0000;
    end else if (ioRead && regHit) begin
      ioRdData <= {clockSourceSel, nominalDivider, autoSpeedSwitchEn, alternateDivider,
                   holdExtension, 2'b00, stopOnHaltAndHold, stopOnHold};
    end else begin
      ioRdData <= 16'h0000;
    end
  end

  // speedup window timer, each event reloads with its own period, except reset, NMI or other IRQ inside a keyboard window
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      windowCnt <= 32'h0;
      kbdWindow <= 1'b0;
    end else if (!autoSpeedSwitchEn) begin
      windowCnt <= 32'h0;
      kbdWindow <= 1'b0;
    end else if (slowIoEvt || diskIrqEvt) begin
      windowCnt <= LONG_CYCLES[31:0];
      kbdWindow <= 1'b0;
    end else if (kbdIrqEvt) begin
      windowCnt <= LONG_CYCLES[31:0];
      kbdWindow <= 1'b1;
    end else if (videoEvt || cpuResetEvt || nmiEvt || otherIrqEvt) begin
      if (videoEvt || !kbdWindow) begin
        windowCnt <= SHORT_CYCLES[31:0];
        kbdWindow <= 1'b0;
      end
    end else if (windowCnt != 32'h0) begin
      windowCnt <= windowCnt - 32'h1;
    end else begin
      kbdWindow <= 1'b0;
    end
  end

  // halt slowdown, released by any interrupt
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      haltSlow <= 1'b0;
    end else if (wakeEvt) begin
      haltSlow <= 1'b0;
    end else if (cpuHalt && !stopOnHaltAndHold && !stopOnHold) begin
      haltSlow <= 1'b1;
    end
  end

  // clock stop request, interrupt restart takes priority
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stopReq <= 1'b0;
    end else if (wakeEvt) begin
      stopReq <= 1'b0;
    end else if (stopOnHaltAndHold && cpuHalt && cpuHold) begin
      stopReq <= 1'b1;
    end else if (stopOnHold && cpuHold) begin
      stopReq <= 1'b1;
    end
  end

  // divider selection
  always_comb begin
    if (fastAsserted) begin
      useAlt = 1'b0;
    end else if (autoSpeedSwitchEn) begin
      useAlt = (windowCnt == 32'h0) | haltSlow;
    end else begin
      useAlt = 1'b1;
    end
    if (useAlt && alternateDivider != CCS_DIV_INPUT) begin
      divCode = alternateDivider;
    end else begin
      divCode = nominalDivider;
    end
  end

  // clock pin direction and stop status
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      processorClockOe <= 1'b1;
      clockStopped <= 1'b0;
    end else begin
      processorClockOe <= (nominalDivider != CCS_DIV_INPUT);
      clockStopped <= divStopped;
    end
  end

  // hold extension after each refresh, refresh itself never gated by stop
  assign effExtension = fastAsserted ? 4'h0 : holdExtension;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      holdCnt <= 12'h0;
      holdExtend <= 1'b0;
    end else if (refreshDone && effExtension != 4'h0) begin
      holdCnt <= 12'(effExtension * CCS_HOLD_STEP_CYCLES) - 12'h1;
      holdExtend <= 1'b1;
    end else if (holdCnt != 12'h0) begin
      holdCnt <= holdCnt - 12'h1;
    end else begin
      holdExtend <= 1'b0;
    end
  end

  ccs_clk_div u_div (
    .clk_sys(clk_sys),
    .rst(rst),
    .srcClk(srcClk),
    .divCode(divCode),
    .stopReq(stopReq),
    .processorClock(processorClock),
    .stopped(divStopped)
  );
endmodule // ccs_cpu_clock_ctrl
`default_nettype wire

/* File: test/ccs_cpu_clock_ctrl_sva.sv */
// assertions on the processor clock control ports
`timescale 1ns/100ps
`default_nettype none
module ccs_cpu_clock_ctrl_sva
  import ccs_pkg::*;
#(
  parameter int LONG_CYCLES = CCS_LONG_CYCLES,
  parameter int SHORT_CYCLES = CCS_SHORT_CYCLES
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [15:0] ioAddr,
  input wire logic ioWrite,
  input wire logic ioRead,
  input wire logic [15:0] ioWrData,
  input wire logic [15:0] ioRdData,
  // status and clock
  input wire logic [2:0] muxSelect,
  input wire logic muxedRequestIn,
  input wire logic muxedPowerCtrlIn,
  input wire logic intrEvt,
  input wire logic nmiEvt,
  input wire logic refreshDone,
  input wire logic holdExtend,
  input wire logic processorClock,
  input wire logic processorClockOe,
  input wire logic clockStopped
);
  int extRun;
  always_ff @(posedge clk_sys) begin
    extRun <= (rst || !holdExtend) ? 0 : extRun + 1;
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_mux_strap: assert property ($fell(rst) |-> muxSelect == 3'h4)
    else $error("select lines not 100 after reset");
  a_strap_dir: assert property ($fell(rst) |-> ##3 processorClockOe == !$past(muxedRequestIn, 3))
    else $error("clock direction does not follow strap");
  a_rsvd_zero: assert property (ioRead && ioAddr == CCS_REG_ADDR |=> ioRdData[3:2] == 2'b00)
    else $error("reserved bits read nonzero");
  a_ext_readback: assert property (ioWrite && ioAddr == CCS_REG_ADDR ##1 ioRead && ioAddr == CCS_REG_ADDR
    |=> ioRdData[7:4] == $past(ioWrData[7:4], 2))
    else $error("hold extension not stored");
  a_ext_cause: assert property ($rose(holdExtend) |-> $past(refreshDone) && $past(muxedPowerCtrlIn, 2))
    else $error("hold extension without refresh or while fast");
  a_ext_cap: assert property (extRun <= 15 * CCS_HOLD_STEP_CYCLES)
    else $error("hold extension too long");
  a_stop_still: assert property (clockStopped && $past(clockStopped) |-> $stable(processorClock))
    else $error("clock moves while stopped");
  a_restart: assert property (clockStopped && (intrEvt || nmiEvt) |-> ##[1:40] !clockStopped)
    else $error("clock not restarted by interrupt");
  c_stopped: cover property ($rose(clockStopped));
  c_extend: cover property ($rose(holdExtend));
  c_strap: cover property ($fell(processorClockOe));
endmodule // ccs_cpu_clock_ctrl_sva
bind ccs_cpu_clock_ctrl ccs_cpu_clock_ctrl_sva #(.LONG_CYCLES(LONG_CYCLES), .SHORT_CYCLES(SHORT_CYCLES)) i_sva (
  .clk_sys, .rst, .ioAddr, .ioWrite, .ioRead, .ioWrData, .ioRdData, .muxSelect, .muxedRequestIn,
  .muxedPowerCtrlIn, .intrEvt, .nmiEvt, .refreshDone, .holdExtend, .processorClock, .processorClockOe,
  .clockStopped);
`default_nettype wire

/* File: test/ccs_cpu_model.sv */
// processor core model driven by the generated clock
`timescale 1ns/100ps
`default_nettype none
module ccs_cpu_model (
  // clocks
  input wire logic clk_sys,
  input wire logic processorClock,
  // bench requests
  input wire logic wantHalt,
  input wire logic wantHold,
  // status
  output logic cpuHalt,
  output logic cpuHold
);
  logic clkSeen;
  always_ff @(posedge clk_sys) begin
    clkSeen <= processorClock;
  end
  // halt entered only on a running clock edge, left when wantHalt drops
  always_ff @(posedge clk_sys) begin
    if (!wantHalt)
      cpuHalt <= 1'b0;
    else if (processorClock && !clkSeen)
      cpuHalt <= 1'b1;
  end
  always_ff @(posedge clk_sys) begin
    cpuHold <= wantHold;
  end
endmodule // ccs_cpu_model
`default_nettype wire

/* File: test/ccs_cpu_clock_ctrl_tb.sv */
// self-checking bench for the processor clock control
`timescale 1ns/100ps
`default_nettype none
module ccs_cpu_clock_ctrl_tb;
  import ccs_pkg::*;
  logic clk_sys = 0, rst = 1, ioWrite = 0, ioRead = 0, muxedRequestIn = 0, muxedPowerCtrlIn = 1;
  logic intrEvt = 0, nmiEvt = 0, refreshDone = 0, srcClk = 0, wantHalt = 0, wantHold = 0, rdPend = 0;
  logic [15:0] ioAddr = 16'h0, ioWrData = 16'h0, d;
  logic [5:0] evt = 6'h0;
  logic [15:0] ioRdData, expQ[$];
  logic [2:0] muxSelect;
  logic cpuHalt, cpuHold, holdExtend, processorClock, processorClockOe, clockSourceSel, clockStopped;
  int errCount = 0, totalChecks = 0;
  int per[7] = '{0, 2, 4, 8, 8, 16, 16};
  int hi[7] = '{0, 1, 2, 2, 6, 2, 14};
  ccs_cpu_clock_ctrl #(.LONG_CYCLES(200), .SHORT_CYCLES(50)) i_ccs_cpu_clock_ctrl (
    .clk_sys, .rst, .ioAddr, .ioWrite, .ioRead, .ioWrData, .ioRdData, .muxSelect, .muxedRequestIn,
    .muxedPowerCtrlIn, .cpuHalt, .cpuHold, .intrEvt, .nmiEvt, .slowIoEvt(evt[0]), .diskIrqEvt(evt[1]),
    .kbdIrqEvt(evt[2]), .otherIrqEvt(evt[3]), .videoEvt(evt[4]), .cpuResetEvt(evt[5]), .refreshDone,
    .holdExtend, .srcClk, .processorClock, .processorClockOe, .clockSourceSel, .clockStopped);
  ccs_cpu_model i_ccs_cpu_model (.clk_sys, .processorClock, .wantHalt, .wantHold, .cpuHalt, .cpuHold);
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) srcClk <= #1 ~srcClk;
  task finalReport;
    $display("checks %0d errors %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chkWord(string s, logic [15:0] e, logic [15:0] g);
    totalChecks++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", s, e, g);
      errCount++;
    end
  endtask
  task chkCnt(string s, int e, int g);
    totalChecks++;
    if (g != e) begin
      $display("mismatch %s expected %0d seen %0d", s, e, g);
      errCount++;
    end
  endtask
  task hang(string s);
    $display("mismatch %s expected done seen timeout", s);
    errCount++;
    finalReport();
  endtask
  // read results taken off the queue one cycle after the read edge
  always @(posedge clk_sys) begin
    if (rdPend) chkWord("rdData", expQ.pop_front(), ioRdData);
    rdPend <= ioRead;
  end
  task tick(int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task wr(logic [15:0] v);
    ioAddr = CCS_REG_ADDR;
    ioWrData = v;
    ioWrite = 1;
    tick(1);
    ioWrite = 0;
  endtask
  task rd(logic [15:0] a, logic [15:0] e);
    expQ.push_back(e);
    ioAddr = a;
    ioRead = 1;
    tick(1);
    ioRead = 0;
    tick(2);
  endtask
  task doReset(logic strap);
    muxedRequestIn = strap;
    rst = 1;
    tick(20);
    rst = 0;
    tick(3);
  endtask
  task waitStop(logic v);
    int n;
    n = 0;
    while (clockStopped !== v && n < 200) begin tick(1); n++; end
    if (n >= 200) hang("clockStopped");
  endtask
  task meas(int eP, int eH);
    int h, l, n;
    h = 0; l = 0; n = 0;
    while (processorClock !== 1'b0 && n < 100) begin tick(1); n++; end
    while (processorClock !== 1'b1 && n < 100) begin tick(1); n++; end
    while (processorClock === 1'b1 && n < 100) begin tick(1); n++; h++; end
    while (processorClock === 1'b0 && n < 100) begin tick(1); n++; l++; end
    if (n >= 100) hang("processorClock");
    chkCnt("clkHigh", eH, h);
    chkCnt("clkPeriod", eP, h + l);
  endtask
  task extLen(int e);
    int h;
    h = 0;
    refreshDone = 1;
    tick(1);
    refreshDone = 0;
    repeat (900) begin if (holdExtend === 1'b1) h++; tick(1); end
    chkCnt("holdLen", e, h);
  endtask
  initial begin
    void'($urandom(93));
    doReset(0);
    chkWord("muxSelect", {13'h0, CCS_MUX_FAST}, {13'h0, muxSelect});
    rd(CCS_REG_ADDR, 16'h1000);
    rd(CCS_REG_ADDR ^ (16'h1 << $urandom_range(15)), 16'h0);
    d = 16'($urandom) & 16'hf7f0;
    wr(d);
    rd(CCS_REG_ADDR, d);
    chkWord("clockSourceSel", {15'h0, d[CCS_SRC_BIT]}, {15'h0, clockSourceSel});
    wr(16'h1030);
    extLen(3 * CCS_HOLD_STEP_CYCLES);
    muxedPowerCtrlIn = 0;
    tick(2);
    extLen(0);
    muxedPowerCtrlIn = 1;
    tick(2);
    extLen(3 * CCS_HOLD_STEP_CYCLES);
    for (int c = 1; c < 7; c++) begin
      muxedPowerCtrlIn = 0;
      wr({1'b0, c[2:0], 1'b0, 3'h2, 8'h0});
      tick(40);
      meas(per[c], hi[c]);
      muxedPowerCtrlIn = 1;
      wr({4'h1, 1'b0, c[2:0], 8'h0});
      tick(40);
      meas(per[c], hi[c]);
    end
    wr(16'h2000);
    tick(40);
    meas(4, 2);
    wr(16'h1e00);
    for (int i = 0; i < 6; i++) begin
      tick(300);
      meas(16, 14);
      evt[i] = 1;
      tick(1);
      evt = 6'h0;
      tick(20);
      meas(2, 1);
      tick(80);
      meas(i < 3 ? 2 : 16, i < 3 ? 1 : 14);
    end
    evt[3] = 1; tick(1); evt = 6'h0; tick(40);
    evt[3] = 1; tick(1); evt = 6'h0; tick(40);
    meas(2, 1);
    evt[0] = 1;
    tick(1);
    evt = 6'h0;
    wantHalt = 1;
    tick(30);
    meas(16, 14);
    intrEvt = 1;
    wantHalt = 0;
    tick(1);
    intrEvt = 0;
    tick(30);
    meas(2, 1);
    evt[2] = 1;
    tick(1);
    evt = 6'h0;
    tick(20);
    evt[4] = 1;
    tick(1);
    evt = 6'h0;
    tick(80);
    meas(16, 14);
    wr(16'h1001);
    wantHold = 1;
    waitStop(1);
    intrEvt = 1; tick(1); intrEvt = 0;
    waitStop(0);
    wantHold = 0;
    rd(CCS_REG_ADDR, 16'h1000);
    wr(16'h1002);
    wantHalt = 1;
    wantHold = 1;
    waitStop(1);
    nmiEvt = 1; wantHalt = 0; tick(1); nmiEvt = 0;
    waitStop(0);
    rd(CCS_REG_ADDR, 16'h1002);
    wantHalt = 1;
    waitStop(1);
    intrEvt = 1; wantHalt = 0; wantHold = 0; tick(1); intrEvt = 0;
    waitStop(0);
    doReset(1);
    rd(CCS_REG_ADDR, 16'h0000);
    doReset(0);
    finalReport();
  end
endmodule // ccs_cpu_clock_ctrl_tb
`default_nettype wire
